// ===== src/lrpc_cfg.svh
// Constants for the line rate and power controller: offsets, fields, timing
`ifndef LRPC_CFG_SVH
`define LRPC_CFG_SVH

// Controller register offsets (byte addresses on the command port)
`define LRPC_REG_CTRL      8'h00
`define LRPC_REG_RATE_TX   8'h04
`define LRPC_REG_RATE_RX   8'h08
`define LRPC_REG_POWER     8'h0c
`define LRPC_REG_OUTCLK    8'h10
`define LRPC_REG_STATUS    8'h14

// Control register fields
`define LRPC_CTRL_START    7:0
`define LRPC_CTRL_FREQ     15:8
`define LRPC_CTRL_TANK_PD  17:16
`define LRPC_CTRL_RING_PD  19:18
`define LRPC_CTRL_PCIE     20
`define LRPC_CTRL_DETECT   24:21

// Power register fields
`define LRPC_PWR_TX        7:0
`define LRPC_PWR_RX        15:8
`define LRPC_PWR_BYP_TX    19:16
`define LRPC_PWR_BYP_RX    23:20
`define LRPC_PWR_NOREF_TX  27:24
`define LRPC_PWR_NOREF_RX  31:28

// Output clock choice fields
`define LRPC_OCLK_TX       11:0
`define LRPC_OCLK_RX       23:12

// Device side widths and codes
`define LRPC_REQ_W         16
`define LRPC_RATE_W        8
`define LRPC_OCLK_REFA     3'h3
`define LRPC_OCLK_REFB     3'h4

// Device register map, reached through the device's own port
`define LRPC_DEV_TRANS_CFG_CH0  16'h0c9f
`define LRPC_DEV_CMUX_CFG_CH0   16'h0ca0
`define LRPC_DEV_TRANS_CFG_CH1  16'h0d9f
`define LRPC_DEV_CMUX_CFG_CH1   16'h0da0
`define LRPC_DEV_TRANS_CFG_CH2  16'h0e9f
`define LRPC_DEV_CMUX_CFG_CH2   16'h0ea0
`define LRPC_DEV_TRANS_CFG_CH3  16'h0f9f
`define LRPC_DEV_CMUX_CFG_CH3   16'h0fa0
`define LRPC_DEV_TIME_LEAVING   29:15
`define LRPC_DEV_TIME_ENTERING  17:9
`define LRPC_DEV_TIME_OTHER     8:0
`define LRPC_DEV_LOOPBACK_CMUX  20
`define LRPC_DEV_TX_CMUX        19

// Settle time after a new rate code, before reset-complete is trusted
`define LRPC_CLK_NS        100
`define LRPC_SETTLE_NS     1000
`define LRPC_SETTLE_CYC    ((`LRPC_SETTLE_NS + `LRPC_CLK_NS - 1) / `LRPC_CLK_NS)

`endif

// ===== src/lrpc_pkg.sv
// Types shared by the line rate and power controller
package lrpc_pkg;

	// Rate change engine states, one-hot
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_REQ  = 5'h02,
		ST_RATE = 5'h04,
		ST_DONE = 5'h08,
		ST_REL  = 5'h10
	} lrpc_state_t;

	// Per-channel power pins driven toward the transceiver
	typedef struct packed {
		logic [1:0] tx_power_state;
		logic [1:0] rx_power_state;
		logic       tx_align_powerdown;
		logic       rx_align_powerdown;
		logic       receiver_detect_req;
		logic       tx_electrical_quiet;
	} lrpc_chan_pwr_t;

endpackage

// ===== src/lrpc_ctrl.sv
// Host-side controller for transceiver line rate changes and power states
`timescale 1ns/1ps
`include "lrpc_cfg.svh"
////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////
module lrpc_ctrl (
	// Clock and reset
	input  wire logic                              ref_clk_i,
	input  wire logic                              rst_n_i,
	// Command register port
	input  wire logic [7:0]                        reg_addr_i,
	input  wire logic [31:0]                       reg_wdata_i,
	input  wire logic                              reg_wr_i,
	input  wire logic                              reg_rd_i,
	output logic [31:0]                            reg_rdata_o,
	// Rate change pins
	output logic [3:0][`LRPC_RATE_W-1:0]           tx_line_rate_sel_o,
	output logic [3:0][`LRPC_RATE_W-1:0]           rx_line_rate_sel_o,
	input  wire logic [3:0]                        tx_reset_complete_i,
	input  wire logic [3:0]                        rx_reset_complete_i,
	output logic [`LRPC_REQ_W-1:0]                 refclk_freq_change_req_o,
	input  wire logic [`LRPC_REQ_W-1:0]            refclk_freq_change_ack_i,
	// PLL pins, one per clock half
	output logic [1:0]                             tank_pll_powerdown_o,
	output logic [1:0]                             ring_pll_powerdown_o,
	input  wire logic [1:0]                        tank_pll_locked_i,
	input  wire logic [1:0]                        ring_pll_locked_i,
	// Channel power pins
	output lrpc_pkg::lrpc_chan_pwr_t [3:0]         chan_power_o
);
	import lrpc_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Functions

	// Collapse a power code to the two valid values outside PCI Express
	function automatic logic [1:0] pair_state(input logic pcie, input logic [1:0] code);
		logic [1:0] res;
		res = code;
		if (!pcie)
		begin
			res = (code != 2'h0) ? 2'h3 : 2'h0;
		end
		return res;
	endfunction

	// Alignment circuit stays powered only in bypass with a live path and clock
	function automatic logic align_pd(input logic bypass, input logic [1:0] ps,
		input logic [2:0] oclk, input logic noref);
		logic refsel;
		refsel = (oclk == `LRPC_OCLK_REFA) || (oclk == `LRPC_OCLK_REFB);
		return !bypass || (ps != 2'h0) || (refsel && noref);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Registers

	logic [31:0]       ctrl;
	logic [31:0]       rate_tx;
	logic [31:0]       rate_rx;
	logic [31:0]       power;
	logic [31:0]       outclk;
	lrpc_state_t       st [8];
	logic [7:0]        cnt [8];
	logic [7:0]        req;
	logic [7:0]        busy;
	logic [7:0]        start;
	logic [7:0]        flag;
	logic [7:0]        done_in;
	logic [7:0]        ack;
	logic              pcie;

	assign pcie    = ctrl[`LRPC_CTRL_PCIE];
	assign done_in = {rx_reset_complete_i, tx_reset_complete_i};
	assign ack     = refclk_freq_change_ack_i[7:0];
	// Start bits are pulses: they act in the write cycle and are never stored
	assign start   = (reg_wr_i && reg_addr_i == `LRPC_REG_CTRL) ?
		reg_wdata_i[`LRPC_CTRL_START] : 8'h00;
	assign flag    = reg_wdata_i[`LRPC_CTRL_FREQ]; // Flag of this write, ctrl still holds the old one

	// Configuration writes; start bits read back as zero
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			ctrl    <= 32'h0;
			rate_tx <= 32'h0;
			rate_rx <= 32'h0;
			power   <= 32'h0;
			outclk  <= 32'h0;
		end
		else if (reg_wr_i)
		begin
			case (reg_addr_i)
				`LRPC_REG_CTRL:    ctrl    <= {reg_wdata_i[31:8], 8'h00};
				`LRPC_REG_RATE_TX: rate_tx <= reg_wdata_i;
				`LRPC_REG_RATE_RX: rate_rx <= reg_wdata_i;
				`LRPC_REG_POWER:   power   <= reg_wdata_i;
				`LRPC_REG_OUTCLK:  outclk  <= {8'h00, reg_wdata_i[23:0]};
				default:           ctrl    <= ctrl;
			endcase
		end
	end

	// Read data, one cycle after the strobe; unmapped offsets read zero
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			reg_rdata_o <= 32'h0;
		end
		else if (reg_rd_i)
		begin
			case (reg_addr_i)
				`LRPC_REG_CTRL:    reg_rdata_o <= ctrl;
				`LRPC_REG_RATE_TX: reg_rdata_o <= rate_tx;
				`LRPC_REG_RATE_RX: reg_rdata_o <= rate_rx;
				`LRPC_REG_POWER:   reg_rdata_o <= power;
				`LRPC_REG_OUTCLK:  reg_rdata_o <= outclk;
				`LRPC_REG_STATUS:  reg_rdata_o <= {4'h0, ring_pll_locked_i,
					tank_pll_locked_i, ack, done_in, busy};
				default:           reg_rdata_o <= 32'h0;
			endcase
		end
		else
		begin
			reg_rdata_o <= 32'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Rate change engines: 0-3 are TX channels, 4-7 RX channels, which is the
	// same order as the request and acknowledge bits

	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			req <= 8'h00;
			for (int e = 0; e < 8; e++)
			begin
				st[e]  <= ST_IDLE;
				cnt[e] <= 8'h00;
			end
		end
		else
		begin
			for (int e = 0; e < 8; e++)
			begin
				case (st[e])
					ST_IDLE:
					begin
						cnt[e] <= 8'h00;
						// A start while busy is ignored; the engine owns the pins
						if (start[e])
						begin
							if (flag[e])
							begin
								req[e] <= 1'b1;
								st[e]  <= ST_REQ;
							end
							else
							begin
								st[e] <= ST_RATE; // Source swap: no request, clocks untouched
							end
						end
					end
					ST_REQ:
					begin
						// Request stays high past the device's answer, until reset-complete returns in ST_DONE
						if (ack[e])
						begin
							st[e] <= ST_RATE;
						end
					end
					ST_RATE:
					begin
						// New code goes out this cycle; the device does the rest
						cnt[e] <= 8'h00;
						st[e]  <= ST_DONE;
					end
					ST_DONE:
					begin
						// Old reset-complete may still be high, so wait out the settle
						if (cnt[e] < 8'(`LRPC_SETTLE_CYC))
						begin
							cnt[e] <= cnt[e] + 8'h01;
						end
						else if (done_in[e])
						begin
							req[e] <= 1'b0;
							st[e]  <= req[e] ? ST_REL : ST_IDLE;
						end
					end
					ST_REL:
					begin
						// Next change only after the acknowledge has dropped
						if (!ack[e])
						begin
							st[e] <= ST_IDLE;
						end
					end
					default:
					begin
						st[e]  <= ST_IDLE;
						req[e] <= 1'b0;
					end
				endcase
			end
		end
	end

	// Busy view for software
	always_comb
	begin
		for (int e = 0; e < 8; e++)
		begin
			busy[e] = (st[e] != ST_IDLE);
		end
	end

	// Rate codes change only when an engine applies them
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			tx_line_rate_sel_o <= '0;
			rx_line_rate_sel_o <= '0;
		end
		else
		begin
			for (int c = 0; c < 4; c++)
			begin
				if (st[c] == ST_RATE)
				begin
					tx_line_rate_sel_o[c] <= rate_tx[c*8 +: 8];
				end
				if (st[c + 4] == ST_RATE)
				begin
					rx_line_rate_sel_o[c] <= rate_rx[c*8 +: 8];
				end
			end
		end
	end

	// Request pins; reserved upper bits held low
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			refclk_freq_change_req_o <= '0;
		end
		else
		begin
			refclk_freq_change_req_o <= {{(`LRPC_REQ_W-8){1'b0}}, req};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Power pins

	// PLL power-down follows software; lock comes back on status
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			tank_pll_powerdown_o <= 2'h0;
			ring_pll_powerdown_o <= 2'h0;
		end
		else
		begin
			tank_pll_powerdown_o <= ctrl[`LRPC_CTRL_TANK_PD];
			ring_pll_powerdown_o <= ctrl[`LRPC_CTRL_RING_PD];
		end
	end

	// Per-channel power states, each direction on its own outside PCI Express
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			// Alignment circuits start powered down, bypass is off by default
			for (int c = 0; c < 4; c++)
			begin
				chan_power_o[c] <= '{2'h0, 2'h0, 1'b1, 1'b1, 1'b0, 1'b0};
			end
		end
		else
		begin
			for (int c = 0; c < 4; c++)
			begin
				logic [1:0] txp;
				logic [1:0] rxp;
				txp = pair_state(pcie, power[c*2 +: 2]);
				// PCI Express mode ties RX state to the TX source
				rxp = pcie ? txp : pair_state(pcie, power[8 + c*2 +: 2]);
				chan_power_o[c].tx_power_state <= txp;
				chan_power_o[c].rx_power_state <= rxp;
				chan_power_o[c].tx_align_powerdown <= align_pd(power[16 + c], txp,
					outclk[c*3 +: 3], power[24 + c]);
				chan_power_o[c].rx_align_powerdown <= align_pd(power[20 + c], rxp,
					outclk[12 + c*3 +: 3], power[28 + c]);
				// Detection only from P1, never outside PCI Express
				chan_power_o[c].receiver_detect_req <= pcie && (txp == 2'h2) &&
					ctrl[21 + c];
				// Quiet tracks the TX power bits outside PCI Express
				chan_power_o[c].tx_electrical_quiet <= pcie ? (txp != 2'h0) : txp[1];
			end
		end
	end

endmodule

// ===== test/lrpc_partner.sv
// Behavioural transceiver quad answering the controller's pins
`timescale 1ns/1ps
module lrpc_partner #(
	parameter int DONE_DLY = 12
) (
	// Clock, reset, answer speed
	input  wire logic            ref_clk_i,
	input  wire logic            rst_n_i,
	input  wire logic            slow_i,
	// Pins from the controller
	input  wire logic [3:0][7:0] tx_rate_i,
	input  wire logic [3:0][7:0] rx_rate_i,
	input  wire logic [15:0]     req_i,
	input  wire logic [3:0]      pd_i,
	// Answers
	output logic [15:0]          ack_o,
	output logic [7:0]           done_o,
	output logic [3:0]           locked_o
);
////////////////////////////////////////
	logic [7:0][15:0] req_hist;
	logic [3:0][3:0]  pd_hist;
	logic [7:0][7:0]  rate;
	logic [7:0][7:0]  last_rate;
	logic [7:0][3:0]  cnt;
	assign rate = {rx_rate_i, tx_rate_i};
	// Requests pass two sync stages; slow mode lags more
	always_ff @(posedge ref_clk_i)
		req_hist <= rst_n_i ? {req_hist[6:0], req_i} : '0;
	assign ack_o = {8'h00, slow_i ? req_hist[7][7:0] : req_hist[1][7:0]};
	// PLL stays down while its pin is high, locks 4 cycles after release
	always_ff @(posedge ref_clk_i)
		for (int i = 0; i < 4; i++)
			pd_hist[i] <= rst_n_i ? {pd_hist[i][2:0], pd_i[i]} : 4'h0;
	// Register contents are not kept: sequence ones rewritten, others left alone
	// New code reruns that direction's reset on its own
	always_ff @(posedge ref_clk_i)
		for (int e = 0; e < 8; e++)
		begin
			last_rate[e] <= rate[e];
			if (!rst_n_i)
				cnt[e] <= 4'h0;
			else if (rate[e] != last_rate[e])
				cnt[e] <= DONE_DLY[3:0];
			else if (cnt[e] != 4'h0)
				cnt[e] <= cnt[e] - 4'h1;
		end
	// Level outputs from the counters and the power-down history
	always_comb
	begin
		for (int e = 0; e < 8; e++)
			done_o[e] = (cnt[e] == 4'h0);
		for (int p = 0; p < 4; p++)
			locked_o[p] = ~|pd_hist[p];
	end
endmodule

// ===== test/lrpc_ctrl_monitor.sv
// Port assertions for the line rate and power controller
`timescale 1ns/1ps
`include "lrpc_cfg.svh"
module lrpc_ctrl_monitor
	import lrpc_pkg::*;
(
	// Clock and reset
	input wire logic                          ref_clk_i,
	input wire logic                          rst_n_i,
	// Observed pins
	input wire logic                          reg_wr_i,
	input wire logic [3:0][`LRPC_RATE_W-1:0]  tx_line_rate_sel_o,
	input wire logic [`LRPC_REQ_W-1:0]        refclk_freq_change_req_o,
	input wire logic [`LRPC_REQ_W-1:0]        refclk_freq_change_ack_i,
	input wire logic [1:0]                    tank_pll_powerdown_o,
	input wire logic [1:0]                    ring_pll_powerdown_o,
	input wire lrpc_pkg::lrpc_chan_pwr_t [3:0] chan_power_o
);
////////////////////////////////////////
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	a_req_reserved_low: assert property (
		refclk_freq_change_req_o[15:8] == 8'h00) else $error("reserved request bit set");
	a_quiet_tracks_tx: assert property (
		chan_power_o[1].tx_electrical_quiet == (chan_power_o[1].tx_power_state != 2'b00))
		else $error("quiet pin wrong");
	a_detect_needs_p1: assert property (
		chan_power_o[2].receiver_detect_req |-> chan_power_o[2].tx_power_state == 2'b10)
		else $error("detect outside P1");
	a_tx_align_off: assert property (
		chan_power_o[3].tx_power_state != 2'b00 |-> chan_power_o[3].tx_align_powerdown)
		else $error("tx align on while down");
	a_rx_align_off: assert property (
		chan_power_o[0].rx_power_state != 2'b00 |-> chan_power_o[0].rx_align_powerdown)
		else $error("rx align on while down");
	a_rate_after_ack: assert property (
		$changed(tx_line_rate_sel_o[1]) && refclk_freq_change_req_o[1]
		|-> $past(refclk_freq_change_ack_i[1])) else $error("rate moved before ack");
	a_req_until_ack: assert property (
		$fell(refclk_freq_change_req_o[1]) |-> $past(refclk_freq_change_ack_i[1]))
		else $error("request dropped before ack");
	a_pll_pd_write: assert property (
		!$past(reg_wr_i) && !$past(reg_wr_i, 2)
		|-> $stable(tank_pll_powerdown_o) && $stable(ring_pll_powerdown_o))
		else $error("pll pin moved without write");
	a_power_write: assert property (
		!$past(reg_wr_i) && !$past(reg_wr_i, 2) |-> $stable(chan_power_o))
		else $error("power pin moved without write");
	c_flag_ack: cover property (refclk_freq_change_req_o[1] && refclk_freq_change_ack_i[1]);
	c_pll_down: cover property (tank_pll_powerdown_o != 2'b00);
	c_detect: cover property (chan_power_o[2].receiver_detect_req);
endmodule
bind lrpc_ctrl lrpc_ctrl_monitor mon (
	.ref_clk_i(ref_clk_i),
	.rst_n_i(rst_n_i),
	.reg_wr_i(reg_wr_i),
	.tx_line_rate_sel_o(tx_line_rate_sel_o),
	.refclk_freq_change_req_o(refclk_freq_change_req_o),
	.refclk_freq_change_ack_i(refclk_freq_change_ack_i),
	.tank_pll_powerdown_o(tank_pll_powerdown_o),
	.ring_pll_powerdown_o(ring_pll_powerdown_o),
	.chan_power_o(chan_power_o)
);

// ===== test/lrpc_ctrl_bench.sv
// Self-checking bench for the line rate and power controller
`timescale 1ns/1ps
`include "lrpc_cfg.svh"
module lrpc_ctrl_bench;
	import lrpc_pkg::*;
////////////////////////////////////////
	logic                  clk = 1'b0;
	logic                  rst_n = 1'b0;
	logic [7:0]            addr = 8'h00;
	logic [31:0]           wdata = 32'h0;
	logic                  wr_s = 1'b0;
	logic                  rd_s = 1'b0;
	logic                  slow = 1'b0;
	logic [31:0]           rdata;
	logic [3:0][7:0]       txr;
	logic [3:0][7:0]       rxr;
	logic [15:0]           req;
	logic [15:0]           ack;
	logic [7:0]            done;
	logic [1:0]            tpd;
	logic [1:0]            rpd;
	logic [3:0]            lk;
	lrpc_chan_pwr_t [3:0]  pwr;
	logic [31:0]           v;
	int                    err_total = 0;
	int                    compares = 0;
	// 10 MHz clock
	always #50 clk = ~clk;
	lrpc_ctrl dut (.ref_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata), .tx_line_rate_sel_o(txr),
		.rx_line_rate_sel_o(rxr), .tx_reset_complete_i(done[3:0]),
		.rx_reset_complete_i(done[7:4]), .refclk_freq_change_req_o(req),
		.refclk_freq_change_ack_i(ack), .tank_pll_powerdown_o(tpd), .ring_pll_powerdown_o(rpd),
		.tank_pll_locked_i(lk[1:0]), .ring_pll_locked_i(lk[3:2]), .chan_power_o(pwr));
	lrpc_partner #(.DONE_DLY(12)) far (.ref_clk_i(clk), .rst_n_i(rst_n), .slow_i(slow),
		.tx_rate_i(txr), .rx_rate_i(rxr), .req_i(req), .pd_i({rpd, tpd}), .ack_o(ack),
		.done_o(done), .locked_o(lk));
	// Verdict and end of run
	task results();
		if (err_total == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			err_total++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task rd(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 v = rdata;
	endtask
	task rc(input logic [7:0] a, input logic [31:0] e, input string n);
		rd(a);
		chk(n, e, v);
	endtask
	// Bounded wait for all engines idle
	task idle();
		for (int i = 0; i < 100; i++)
		begin
			rd(`LRPC_REG_STATUS);
			if (v[7:0] === 8'h00)
				return;
		end
		err_total++;
		results();
	endtask
	task settle();
		repeat (2) @(posedge clk);
		#1;
	endtask
	initial
	begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		#1 chk("reset power", 32'h0c0c0c0c, pwr);
		rc(`LRPC_REG_STATUS, 32'h0f00ff00, "status");
		rc(8'h18, 32'h0, "unmapped");
		wr(8'h1c, 32'hffffffff);
		wr(`LRPC_REG_STATUS, 32'hffffffff);
		rc(`LRPC_REG_STATUS, 32'h0f00ff00, "status ro");
		wr(`LRPC_REG_RATE_TX, 32'h25);
		wr(`LRPC_REG_RATE_RX, 32'h5a000000);
		wr(`LRPC_REG_CTRL, 32'h81);
		rd(`LRPC_REG_STATUS);
		chk("busy", 32'h81, v & 32'hff);
		idle();
		chk("tx rate", 32'h25, txr);
		chk("rx rate", 32'h5a000000, rxr);
		slow <= 1'b1;
		wr(`LRPC_REG_RATE_TX, 32'h4425);
		wr(`LRPC_REG_RATE_RX, 32'h5a770000);
		wr(`LRPC_REG_CTRL, 32'h4242);
		settle();
		chk("request", 32'h42, {16'h0, req});
		idle();
		chk("flag rates", 32'h4425, txr);
		chk("flag rx rate", 32'h5a770000, rxr);
		rc(`LRPC_REG_STATUS, 32'h0f00ff00, "ack low");
		slow <= 1'b0;
		wr(`LRPC_REG_RATE_TX, 32'h3325);
		wr(`LRPC_REG_CTRL, 32'h0202);
		idle();
		chk("prompt rate", 32'h3325, txr);
		wr(`LRPC_REG_CTRL, 32'h00090000);
		settle();
		chk("pll pd", 32'h9, {28'h0, rpd, tpd});
		repeat (6) @(posedge clk);
		rc(`LRPC_REG_STATUS, 32'h0600ff00, "unlock");
		wr(`LRPC_REG_CTRL, 32'h0);
		repeat (8) @(posedge clk);
		rc(`LRPC_REG_STATUS, 32'h0f00ff00, "relock");
		wr(`LRPC_REG_CTRL, 32'h01f00000);
		wr(`LRPC_REG_POWER, 32'h01ff00e4);
		wr(`LRPC_REG_OUTCLK, 32'h3);
		settle();
		chk("pcie power", 32'hfdaf5d08, pwr);
		rc(`LRPC_REG_POWER, 32'h01ff00e4, "power reg");
		wr(`LRPC_REG_CTRL, 32'h01e00000);
		wr(`LRPC_REG_POWER, 32'h00ff03e4);
		wr(`LRPC_REG_OUTCLK, 32'h0);
		settle();
		chk("plain power", 32'hc9c9c934, pwr);
		// Device map field positions kept for the device port
		v = 32'h0;
		v[`LRPC_DEV_TIME_LEAVING] = '1;
		chk("leaving field", 32'h3fff8000, v);
		v = 32'h0;
		v[`LRPC_DEV_TIME_ENTERING] = '1;
		chk("entering field", 32'h0003fe00, v);
		v = 32'h0;
		v[`LRPC_DEV_TIME_OTHER] = '1;
		chk("other field", 32'h000001ff, v);
		v = 32'h0;
		v[`LRPC_DEV_LOOPBACK_CMUX] = 1'b1;
		v[`LRPC_DEV_TX_CMUX] = 1'b1;
		chk("clock mux bits", 32'h00180000, v);
		results();
	end
endmodule
